// ### testbench.sv
// Self-checking bench for result coding, remote averaging and diode faults.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import trf_pkg::*;
;
  logic ref_clk, rstn, conv_busy, local_done, remote_done, fault_cmp_pin, short_det_pin;
  logic signed [11:0] raw_temp, remote_compare_value;
  logic remote_compare_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] notes[$];
  int hist[$];
  int cq[$];
  logic [1:0] bq[$];
  int n_fail, comparisons, cycles, cx;
  int lim[4] = '{-1025, -1024, -1, 2047};

  trf_result_filter u_trf_result_filter (.ref_clk, .rstn, .conv_busy, .local_done,
    .remote_done, .raw_temp, .fault_cmp_pin, .short_det_pin, .remote_compare_value,
    .remote_compare_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  trf_fe_model u_trf_fe_model (.ref_clk, .conv_busy, .local_done, .remote_done, .raw_temp,
    .fault_cmp_pin, .short_det_pin);

  // Free-running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Hang guard: the whole run needs far fewer cycles than this.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Each read answer is matched against the oldest noted expectation.
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, notes.pop_front());
  end

  // Each write answer is matched against the oldest noted response code.
  always @(posedge ref_clk) begin
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.pop_front());
  end

  // Each compare strobe takes the oldest noted mean; -1 marks a mean that is not exact.
  always @(posedge ref_clk) begin
    if (remote_compare_valid) begin
      cx = cq.pop_front();
      if (cx >= 0) check({22'h0, remote_compare_value}, cx);
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // extended offset, negatives clamp, fraction left-justified
  function automatic logic [31:0] fmt(input int v, input logic ext);
    int u;
    u = v + (ext ? 1024 : 0);
    if (u < 0) u = 0;
    return {16'h0, u[11:4], u[3:0], 4'h0};
  endfunction : fmt

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bq.push_back((a inside {TRF_OFF_CONFIG, TRF_OFF_FILTER, TRF_OFF_STATUS}) ? TRF_RESP_OKAY
      : TRF_RESP_SLVERR);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready));
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    notes.push_back(e);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  // window of n whole-degree samples, checked where the mean is exact
  task automatic rsample(input int t, input int n);
    int s;
    hist.push_back(t >>> 4);
    if (hist.size() > n) void'(hist.pop_front());
    s = hist.sum() * 16;
    cq.push_back((s % hist.size() == 0) ? s / hist.size() : -1);
    u_trf_fe_model.conv(1'b1, t[11:0], 1'b0, 1'b0);
    if (s % hist.size() == 0) rd(TRF_OFF_REMOTE, {TRF_RESP_OKAY, fmt(s / hist.size(), 0)});
  endtask : rsample

  // Main sequence of tests.
  initial begin
    rstn = 1'b0;
    seed = 32'h9609;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(TRF_OFF_FILTER, {TRF_RESP_OKAY, 32'h0});
    rd(TRF_OFF_STATUS, {TRF_RESP_OKAY, 32'h0});
    rd(8'h20, {TRF_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h4);
    rd(TRF_OFF_CONFIG, {TRF_RESP_OKAY, 32'h0});
    $display("reset test done");
    // boundary local results in standard coding, random local results in both codings
    for (int e = 0; e < 2; e++) begin
      wr(TRF_OFF_CONFIG, {29'h0, e[0], 2'h0});
      for (int i = 0; i < 8; i++) begin
        seed = xs(seed);
        if (i >= 4) lim[i % 4] = int'($signed(seed[11:0]));
        u_trf_fe_model.conv(1'b0, lim[i % 4][11:0], 1'b0, 1'b0);
        rd(TRF_OFF_LOCAL, {TRF_RESP_OKAY, fmt(lim[i % 4], e[0])});
      end
    end
    $display("coding test done");
    // coding change mid-conversion waits for the next one
    fork
      u_trf_fe_model.conv(1'b0, 12'h100, 1'b0, 1'b0);
      begin
        repeat (2) @(posedge ref_clk);
        wr(TRF_OFF_CONFIG, 32'h0);
      end
    join
    rd(TRF_OFF_LOCAL, {TRF_RESP_OKAY, fmt(256, 1)});
    u_trf_fe_model.conv(1'b0, 12'h100, 1'b0, 1'b0);
    rd(TRF_OFF_LOCAL, {TRF_RESP_OKAY, fmt(256, 0)});
    $display("range switch test done");
    // each level change restarts the window
    for (int lv = 0; lv < 3; lv++) begin
      wr(TRF_OFF_FILTER, lv);
      hist.delete();
      for (int i = 0; i < 9; i++) begin
        seed = xs(seed);
        rsample(160 + (lv == 0 ? 0 : int'(seed[5:0])), lv == 0 ? 1 : 4 * lv);
      end
    end
    wr(TRF_OFF_FILTER, 32'h3);
    rd(TRF_OFF_FILTER, {TRF_RESP_OKAY, 32'h2});
    // An ignored code keeps the full window; this sample makes its mean exact.
    rsample(16 * (16 + ((hist[0] - hist.sum()) % 8 + 8) % 8), 8);
    wr(TRF_OFF_FILTER, 32'h0);
    $display("filter test done");
    // shorted diode reads minus 64 in extended coding
    wr(TRF_OFF_CONFIG, 32'h4);
    u_trf_fe_model.conv(1'b1, 12'h190, 1'b0, 1'b1);
    rd(TRF_OFF_REMOTE, {TRF_RESP_OKAY, 32'h0});
    // brief fault mid-conversion sets the sticky open flag
    cq.push_back(400);
    u_trf_fe_model.conv(1'b1, 12'h190, 1'b1, 1'b0);
    rd(TRF_OFF_REMOTE, {TRF_RESP_OKAY, fmt(400, 1)});
    rd(TRF_OFF_STATUS, {TRF_RESP_OKAY, 32'h4});
    wr(TRF_OFF_STATUS, 32'h4);
    rd(TRF_OFF_STATUS, {TRF_RESP_OKAY, 32'h0});
    $display("fault test done");
    check(cq.size(), 0);
    check(bq.size(), 0);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

// ### trf_fe_model.sv
// Behavioural model of the conversion front end and diode fault comparators.
`timescale 1ns/1ns
`default_nettype none
module trf_fe_model (
  input wire logic ref_clk,
  output logic conv_busy,
  output logic local_done,
  output logic remote_done,
  output logic signed [11:0] raw_temp,
  output logic fault_cmp_pin,
  output logic short_det_pin
);
  // Idle front end: no conversion, no fault, data line noisy.
  initial begin
    {conv_busy, local_done, remote_done, fault_cmp_pin, short_det_pin} = '0;
    raw_temp = 12'h5a5;
  end

  // One conversion of seven cycles; the fault blip ends early to prove continuous sampling.
  task automatic conv(input logic rem, input logic [11:0] t, input logic flt, input logic sht);
    short_det_pin <= sht;
    conv_busy <= 1'b1;
    repeat (2) @(posedge ref_clk);
    fault_cmp_pin <= flt;
    repeat (2) @(posedge ref_clk);
    fault_cmp_pin <= 1'b0;
    repeat (2) @(posedge ref_clk);
    raw_temp <= t;
    local_done <= !rem;
    remote_done <= rem;
    @(posedge ref_clk);
    // Result is only valid with its pulse, so the line toggles afterwards.
    raw_temp <= ~t;
    {local_done, remote_done, conv_busy, short_det_pin} <= '0;
    @(posedge ref_clk);
  endtask : conv
endmodule : trf_fe_model
`default_nettype wire

// ### trf_hist_if.sv
// Interface carrying the remote sample history handshake between filter and memory.
`timescale 1ns/1ns
`default_nettype none
interface trf_hist_if;
  logic clear;
  logic push;
  logic signed [11:0] sample;
  logic signed [15:0] sum4;
  logic signed [15:0] sum8;
  logic [3:0] count;
  modport ctrl (output clear, output push, output sample, input sum4, input sum8, input count);
  modport mem (input clear, input push, input sample, output sum4, output sum8, output count);
endinterface : trf_hist_if
`default_nettype wire

// ### trf_hist_mem.sv
// Eight entry sample history with registered running sums of the last four and eight samples.
`timescale 1ns/1ns
`default_nettype none
module trf_hist_mem
  import trf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  trf_hist_if.mem hist
);
  logic signed [11:0] entry_reg [TRF_HIST_DEPTH];
  logic signed [15:0] sum4_reg;
  logic signed [15:0] sum8_reg;
  logic [3:0] count_reg;

  // Shift register of samples; entry 0 is the newest.
  genvar gi;
  generate
    for (gi = 0; gi < TRF_HIST_DEPTH; gi++) begin : g_entry
      logic signed [11:0] feed;
      // The head is chosen at elaboration, so no index ever points below entry 0.
      if (gi == 0) begin : g_head
        assign feed = hist.sample;
      end else begin : g_tail
        assign feed = entry_reg[gi-1];
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          entry_reg[gi] <= 12'h000;
        end else if (hist.clear) begin
          entry_reg[gi] <= 12'h000;
        end else if (hist.push) begin
          entry_reg[gi] <= feed;
        end
      end
    end
  endgenerate

  // Running sums drop the oldest entry, so no adder tree is needed.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sum4_reg <= 16'h0000;
      sum8_reg <= 16'h0000;
      count_reg <= 4'h0;
    end else if (hist.clear) begin
      sum4_reg <= 16'h0000;
      sum8_reg <= 16'h0000;
      count_reg <= 4'h0;
    end else if (hist.push) begin
      sum4_reg <= sum4_reg + 16'(hist.sample) - 16'(entry_reg[3]);
      sum8_reg <= sum8_reg + 16'(hist.sample) - 16'(entry_reg[7]);
      if (count_reg != 4'h8) begin
        count_reg <= count_reg + 4'h1;
      end
    end
  end

  assign hist.sum4 = sum4_reg;
  assign hist.sum8 = sum8_reg;
  assign hist.count = count_reg;
endmodule : trf_hist_mem
`default_nettype wire

// ### trf_pkg.sv
// Package with register map, field positions and coding constants for the result filter.
package trf_pkg;
  localparam logic [7:0] TRF_OFF_CONFIG = 8'h00;
  localparam logic [7:0] TRF_OFF_FILTER = 8'h04;
  localparam logic [7:0] TRF_OFF_STATUS = 8'h08;
  localparam logic [7:0] TRF_OFF_LOCAL = 8'h0c;
  localparam logic [7:0] TRF_OFF_REMOTE = 8'h10;
  localparam int TRF_CFG_RANGE_BIT = 2;
  localparam int TRF_STAT_OPEN_BIT = 2;
  localparam logic [1:0] TRF_FILT_RESET = 2'h0;
  localparam logic [1:0] TRF_FILT_OFF = 2'h0;
  localparam logic [1:0] TRF_FILT_L1 = 2'h1;
  localparam logic [1:0] TRF_FILT_L2 = 2'h2;
  localparam logic [7:0] TRF_STD_MAX = 8'h7f;
  localparam logic [7:0] TRF_EXT_OFFSET = 8'h40;
  localparam logic [7:0] TRF_SHORT_CODE = 8'h00;
  localparam logic [1:0] TRF_RESP_OKAY = 2'h0;
  localparam logic [1:0] TRF_RESP_SLVERR = 2'h2;
  localparam int TRF_HIST_DEPTH = 8;
endpackage : trf_pkg

// ### trf_result_filter.sv
// Temperature result formatter, remote moving-average filter and diode fault flags.
// What this block does
// - Each channel result is integer plus fraction byte.
// - Integer byte counts one per degree.
// - Fraction byte holds sixteenths, left-justified.
// - Only upper four fraction bits carry value.
// - Standard coding clamps negatives to zero.
// - Extended coding offsets so zero means minus 64.
// - Remote-only filter with two averaging levels.
// - Level one averages four latest samples.
// - Level two averages eight latest samples.
// - Remote register and comparisons use filtered value.
// - Filter disabled at reset.
// - Shorted diode reports minus 64 degrees in extended coding, zero in standard.
// - Fault comparator sampled throughout each conversion.
// - Fault sets open flag, status bit two.
// - Config bit two selects extended, next conversion.
// - Standard coding saturates at 127.
// - Extended equals standard plus 64 for non-negative results.
`timescale 1ns/1ns
`default_nettype none
module trf_result_filter
  import trf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic conv_busy,
  input wire logic local_done,
  input wire logic remote_done,
  input wire logic signed [11:0] raw_temp,
  input wire logic fault_cmp_pin,
  input wire logic short_det_pin,
  output logic signed [11:0] remote_compare_value,
  output logic remote_compare_valid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  trf_hist_if hist ();

  trf_hist_mem u_hist (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .hist(hist)
  );

  logic cfg_range_reg;
  logic [1:0] filt_level_reg;
  logic open_flag_reg;
  logic [15:0] local_result_reg;
  logic [15:0] remote_result_reg;
  logic range_active_reg;
  logic fault_seen_reg;
  logic busy_d_reg;
  logic [1:0] fault_sync_reg;
  logic [1:0] short_sync_reg;
  logic filter_push_reg;
  logic signed [11:0] remote_raw_reg;
  logic restart_filter;
  logic open_clear;

  // Pin-side comparator outputs are asynchronous; two flops before use.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_sync_reg <= 2'b00;
      short_sync_reg <= 2'b00;
    end else begin
      fault_sync_reg <= {fault_sync_reg[0], fault_cmp_pin};
      short_sync_reg <= {short_sync_reg[0], short_det_pin};
    end
  end

  // Coding choice is latched at conversion start so a change only takes effect next time.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_d_reg <= 1'b0;
      range_active_reg <= 1'b0;
    end else begin
      busy_d_reg <= conv_busy;
      if (conv_busy && !busy_d_reg) begin
        range_active_reg <= cfg_range_reg;
      end
    end
  end

  // Fault watch spans the whole conversion; any trip during it counts.
  // The flag logic also looks at the done cycle itself, so a late trip is not lost.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_seen_reg <= 1'b0;
    end else if (conv_busy && !busy_d_reg) begin
      fault_seen_reg <= fault_sync_reg[1];
    end else if (conv_busy && fault_sync_reg[1]) begin
      fault_seen_reg <= 1'b1;
    end
  end

  // Format a signed 1/16 degree sample into the high and low byte pair.
  function automatic logic [15:0] fmt_temp(input logic signed [11:0] t, input logic ext);
    logic signed [8:0] whole;
    logic [7:0] hi;
    logic [7:0] lo;
    // A 12-bit sample tops out below 128 degrees, so saturation is only a guard.
    whole = 9'(t >>> 4);
    lo = {t[3:0], 4'h0};
    if (ext) begin
      if (whole < -9'sd64) begin
        hi = 8'h00;
        lo = 8'h00;
      end else begin
        hi = 8'(whole + 9'sd64);
      end
    end else if (whole < 0) begin
      hi = 8'h00;
      lo = 8'h00;
    end else if (whole > 9'sd127) begin
      hi = TRF_STD_MAX;
      lo = 8'h00;
    end else begin
      hi = whole[7:0];
    end
    return {hi, lo};
  endfunction : fmt_temp

  // Filter output; until a window fills, the samples taken so far are averaged.
  // Division only serves partial windows, trading some area for a faster settle.
  logic signed [11:0] avg_value;
  always_comb begin
    avg_value = remote_raw_reg;
    if (filt_level_reg == TRF_FILT_L1 && hist.count >= 4'h4) begin
      avg_value = 12'(hist.sum4 >>> 2);
    end else if (filt_level_reg == TRF_FILT_L2 && hist.count == 4'h8) begin
      avg_value = 12'(hist.sum8 >>> 3);
    end else if (filt_level_reg != TRF_FILT_OFF) begin
      avg_value = 12'(hist.sum8 / $signed({12'h000, hist.count}));
    end
  end

  assign hist.push = remote_done && !short_sync_reg[1];
  assign hist.sample = {raw_temp[11:4], 4'h0};
  assign hist.clear = restart_filter;

  // Result registers; local bypasses the filter, remote uses its output one cycle later.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      local_result_reg <= 16'h0000;
      remote_result_reg <= 16'h0000;
      filter_push_reg <= 1'b0;
      remote_raw_reg <= 12'h000;
    end else begin
      filter_push_reg <= hist.push;
      if (local_done) begin
        local_result_reg <= fmt_temp(raw_temp, range_active_reg);
      end
      if (remote_done && short_sync_reg[1]) begin
        remote_result_reg <= range_active_reg ? {TRF_SHORT_CODE, 8'h00} : 16'h0000;
      end else if (hist.push) begin
        remote_raw_reg <= {raw_temp[11:4], 4'h0};
      end
      if (filter_push_reg) begin
        remote_result_reg <= fmt_temp(avg_value, range_active_reg);
      end
    end
  end

  // Comparators downstream see the filtered value, strobed when it lands.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      remote_compare_value <= 12'h000;
      remote_compare_valid <= 1'b0;
    end else begin
      remote_compare_valid <= filter_push_reg;
      if (filter_push_reg) begin
        remote_compare_value <= avg_value;
      end
    end
  end

  // AXI4-Lite write: both channels are accepted together when both are present.
  // Holding both readies low while an answer waits keeps one write in flight.
  logic wr_go;
  logic [7:0] wr_addr;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wr_addr = s_axi_awaddr[7:0];
  // The ignored level code leaves the level alone, so it must not wipe the window either.
  assign restart_filter = wr_go && s_axi_wstrb[0] && wr_addr == TRF_OFF_FILTER
    && s_axi_awaddr[31:8] == 24'h000000 && s_axi_wdata[1:0] != filt_level_reg
    && s_axi_wdata[1:0] != 2'h3;
  assign open_clear = wr_go && s_axi_wstrb[0] && s_axi_awaddr[31:8] == 24'h000000
    && wr_addr == TRF_OFF_STATUS && s_axi_wdata[TRF_STAT_OPEN_BIT];

  // Control registers written by software.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_range_reg <= 1'b0;
      filt_level_reg <= TRF_FILT_RESET;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr[31:8] == 24'h000000) begin
      if (wr_addr == TRF_OFF_CONFIG) begin
        cfg_range_reg <= s_axi_wdata[TRF_CFG_RANGE_BIT];
      end
      if (wr_addr == TRF_OFF_FILTER && s_axi_wdata[1:0] != 2'h3) begin
        filt_level_reg <= s_axi_wdata[1:0];
      end
    end
  end

  // Open flag is sticky; write one clears, and a fault in the same cycle wins.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      open_flag_reg <= 1'b0;
    end else if (remote_done && (fault_seen_reg || fault_sync_reg[1])) begin
      open_flag_reg <= 1'b1;
    end else if (open_clear) begin
      open_flag_reg <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TRF_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (s_axi_awaddr[31:8] == 24'h000000 && (wr_addr == TRF_OFF_CONFIG
          || wr_addr == TRF_OFF_FILTER || wr_addr == TRF_OFF_STATUS)) begin
        s_axi_bresp <= TRF_RESP_OKAY;
      end else begin
        s_axi_bresp <= TRF_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one read in flight, data registered with its response.
  // Unmapped offsets answer zero data with a slave error and change nothing.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TRF_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= TRF_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr[31:8] != 24'h000000) begin
        s_axi_rresp <= TRF_RESP_SLVERR;
      end else begin
        case (s_axi_araddr[7:0])
          TRF_OFF_CONFIG: s_axi_rdata <= {29'h0, cfg_range_reg, 2'h0};
          TRF_OFF_FILTER: s_axi_rdata <= {30'h0, filt_level_reg};
          TRF_OFF_STATUS: s_axi_rdata <= {29'h0, open_flag_reg, 2'h0};
          TRF_OFF_LOCAL: s_axi_rdata <= {16'h0, local_result_reg};
          TRF_OFF_REMOTE: s_axi_rdata <= {16'h0, remote_result_reg};
          default: s_axi_rresp <= TRF_RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : trf_result_filter
`default_nettype wire

// ### trf_result_filter_chk.sv
// Checker for bus handshakes and remote compare timing of the result filter.
`timescale 1ns/1ns
`default_nettype none
module trf_result_filter_chk
  import trf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic remote_done,
  input wire logic short_det_pin,
  input wire logic remote_compare_valid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h10
    |=> s_axi_rresp == TRF_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  cmp_late_a: assert property (remote_done && !short_det_pin |-> ##2 remote_compare_valid)
    else $error("compare value not updated");
  cmp_once_a: assert property (remote_compare_valid |-> $past(remote_done, 2))
    else $error("compare update without conversion");
  cover property (remote_compare_valid);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == TRF_RESP_SLVERR);
endmodule : trf_result_filter_chk
bind trf_result_filter trf_result_filter_chk u_trf_result_filter_chk (.ref_clk, .rstn,
  .remote_done, .short_det_pin, .remote_compare_valid, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
